// *** hw/dtc_timer.sv ***
// The Avalon-MM interface to the registers was chosen for this implementation.
`timescale 1ns/100ps
module dtc_timer (
	input wire logic clk,
	input wire logic rst,
	input wire logic [dtc_pkg::ADDR_W-1:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	output logic [31:0] readdata,
	output logic waitrequest,
	input wire logic count_input_first,
	input wire logic count_input_second,
	input wire logic gate_input_first,
	input wire logic gate_input_second,
	input wire logic vector_ack_first,
	input wire logic vector_ack_second,
	output logic overflow_flag_first,
	output logic overflow_flag_second,
	output logic baud_tick,
	output logic irq
);

	// ***************************************************
	// machine cycle phase divider
	// ***************************************************
	logic [3:0] phase_r; // 0..11 within machine cycle
	logic sample_stb; // pin sample phase
	logic update_stb; // count update phase, one per machine cycle
	assign sample_stb = (phase_r == dtc_pkg::INPUT_SAMPLE_PHASE);
	assign update_stb = (phase_r == dtc_pkg::COUNT_UPDATE_PHASE);

	// free running, never stopped by software
	always_ff @(posedge clk) begin
		if (rst || phase_r == dtc_pkg::PHASE_LAST) begin
			phase_r <= 4'h0;
		end else begin
			phase_r <= phase_r + 4'h1;
		end
	end

	// ***************************************************
	// pin synchronisers, order: gate1 gate0 count1 count0
	// ***************************************************
	logic [3:0] pin_meta_r; // first stage, read only by second
	logic [3:0] pin_sync_r; // safe levels
	always_ff @(posedge clk) begin
		if (rst) begin
			pin_meta_r <= 4'h0;
			pin_sync_r <= 4'h0;
		end else begin
			pin_meta_r <= {gate_input_second, gate_input_first, count_input_second, count_input_first};
			pin_sync_r <= pin_meta_r;
		end
	end

	// ***************************************************
	// register bus, one wait cycle then answer
	// ***************************************************
	logic wait_r; // waitrequest flop, high when idle
	logic [31:0] rdata_r; // read data flop
	logic req; // read or write asserted
	logic acc; // completing edge
	logic [7:0] idx; // register index
	assign req = read | write;
	assign acc = req & ~wait_r;
	assign idx = address[dtc_pkg::ADDR_W-1:2];

	// write strobes per register
	logic wr_timer_control, wr_timer_mode_control, wr_stat, wr_mask;
	logic [1:0] wr_low, wr_high; // per timer count byte writes
	assign wr_timer_control = acc & write & (idx == dtc_pkg::IDX_TIMER_CONTROL);
	assign wr_timer_mode_control = acc & write & (idx == dtc_pkg::IDX_TIMER_MODE_CONTROL);
	assign wr_stat = acc & write & (idx == dtc_pkg::IDX_IRQ_STATUS);
	assign wr_mask = acc & write & (idx == dtc_pkg::IDX_IRQ_MASK);
	assign wr_low[0] = acc & write & (idx == dtc_pkg::IDX_LOW_COUNT_BYTE_FIRST);
	assign wr_low[1] = acc & write & (idx == dtc_pkg::IDX_LOW_COUNT_BYTE_SECOND);
	assign wr_high[0] = acc & write & (idx == dtc_pkg::IDX_HIGH_COUNT_BYTE_FIRST);
	assign wr_high[1] = acc & write & (idx == dtc_pkg::IDX_HIGH_COUNT_BYTE_SECOND);

	// ***************************************************
	// control state
	// ***************************************************
	logic [1:0] run_r; // run_bit_second, run_bit_first
	logic [1:0] flag_r; // overflow_flag_second, overflow_flag_first
	dtc_pkg::dtc_mode_reg_t timer_mode_control_r; // timer_mode_control
	logic [1:0] stat_r; // sticky overflow events
	logic [1:0] mask_r; // interrupt enables
	logic [7:0] low_r [2]; // low count bytes
	logic [7:0] high_r [2]; // high count bytes
	logic [7:0] timer_control_rd; // timer_control as read
	assign timer_control_rd = {flag_r[1], run_r[1], flag_r[0], run_r[0], 4'h0};

	// read mux, unmapped and unused bits read zero
	logic [7:0] rd_mux;
	assign rd_mux = (idx == dtc_pkg::IDX_TIMER_CONTROL) ? timer_control_rd :
		(idx == dtc_pkg::IDX_TIMER_MODE_CONTROL) ? timer_mode_control_r :
		(idx == dtc_pkg::IDX_LOW_COUNT_BYTE_FIRST) ? low_r[0] :
		(idx == dtc_pkg::IDX_LOW_COUNT_BYTE_SECOND) ? low_r[1] :
		(idx == dtc_pkg::IDX_HIGH_COUNT_BYTE_FIRST) ? high_r[0] :
		(idx == dtc_pkg::IDX_HIGH_COUNT_BYTE_SECOND) ? high_r[1] :
		(idx == dtc_pkg::IDX_IRQ_STATUS) ? {6'h00, stat_r} :
		(idx == dtc_pkg::IDX_IRQ_MASK) ? {6'h00, mask_r} : 8'h00;

	// waitrequest drops for the edge after a request appears
	always_ff @(posedge clk) begin
		if (rst) begin
			wait_r <= 1'b1;
			rdata_r <= 32'h0000_0000;
		end else begin
			wait_r <= ~(req & wait_r);
			if (req & wait_r) begin
				rdata_r <= {24'h00_0000, rd_mux};
			end
		end
	end
	assign waitrequest = wait_r;
	assign readdata = rdata_r;

	// ***************************************************
	// count enables
	// ***************************************************
	logic [1:0] mode_split; // mode 3 per timer
	logic [1:0] gate_open; // run and gate condition
	logic [1:0] edge_r; // falling edge awaiting update
	logic [1:0] smp_r; // last sample of count pins
	logic [1:0] tick; // one count step this cycle
	logic high_tick; // first high byte in split mode
	logic [1:0] sel_ct; // counter select
	assign mode_split[0] = (dtc_pkg::dtc_mode_t'({timer_mode_control_r.first.mode_select_high,
		timer_mode_control_r.first.mode_select_low}) == dtc_pkg::MODE_SPLIT);
	assign mode_split[1] = (dtc_pkg::dtc_mode_t'({timer_mode_control_r.second.mode_select_high,
		timer_mode_control_r.second.mode_select_low}) == dtc_pkg::MODE_SPLIT);
	assign sel_ct = {timer_mode_control_r.second.count_select, timer_mode_control_r.first.count_select};
	assign gate_open[0] = run_r[0] & (~timer_mode_control_r.first.gate | pin_sync_r[2]);
	assign gate_open[1] = run_r[1] & (~timer_mode_control_r.second.gate | pin_sync_r[3]) & ~mode_split[1];
	assign high_tick = update_stb & run_r[1] & mode_split[0];

	// sample once per machine cycle, keep edge until next update
	always_ff @(posedge clk) begin
		if (rst) begin
			smp_r <= 2'h0;
			edge_r <= 2'h0;
		end else if (sample_stb) begin
			smp_r <= pin_sync_r[1:0];
			edge_r <= smp_r & ~pin_sync_r[1:0];
		end else if (update_stb) begin
			edge_r <= 2'h0;
		end
	end

	// ***************************************************
	// counting step, shared by both timers
	// ***************************************************
	function automatic dtc_pkg::dtc_step_t step_f(input logic [1:0] mode, input logic [7:0] low,
		input logic [7:0] high);
		logic [12:0] c13;
		logic [15:0] c16;
		dtc_pkg::dtc_step_t s;
		c13 = {high, low[4:0]};
		c16 = {high, low};
		s = '{low: low, high: high, ovf: 1'b0};
		case (dtc_pkg::dtc_mode_t'(mode))
			dtc_pkg::MODE_13BIT: begin
				// upper three low bits left as they are
				s.ovf = &c13;
				c13 = c13 + 13'h0001;
				s.high = c13[12:5];
				s.low = {low[7:5], c13[4:0]};
			end
			dtc_pkg::MODE_16BIT: begin
				s.ovf = &c16;
				c16 = c16 + 16'h0001;
				s.high = c16[15:8];
				s.low = c16[7:0];
			end
			dtc_pkg::MODE_RELOAD: begin
				s.ovf = &low;
				s.low = (&low) ? high : low + 8'h01;
			end
			default: begin
				// split mode: low byte counts alone
				s.ovf = &low;
				s.low = low + 8'h01;
			end
		endcase
		return s;
	endfunction : step_f

	dtc_pkg::dtc_step_t nxt [2]; // step result per timer
	logic [1:0] ovf_ev; // overflow pulses per timer
	logic high_ovf; // first high byte wrap in split mode

	// ***************************************************
	// per timer count bytes
	// ***************************************************
	for (genvar i = 0; i < 2; i++) begin : g_timer
		// cycles or pin edges, gated
		assign tick[i] = update_stb & gate_open[i] & (sel_ct[i] ? edge_r[i] : 1'b1);
		assign nxt[i] = step_f(i == 0 ? {timer_mode_control_r.first.mode_select_high, timer_mode_control_r.first.mode_select_low} :
			{timer_mode_control_r.second.mode_select_high, timer_mode_control_r.second.mode_select_low}, low_r[i], high_r[i]);
		assign ovf_ev[i] = tick[i] & nxt[i].ovf;

		// bus write beats the count in the same cycle; run bit never clears counts
		always_ff @(posedge clk) begin
			if (rst) begin
				low_r[i] <= dtc_pkg::COUNT_BYTE_RST;
				high_r[i] <= dtc_pkg::COUNT_BYTE_RST;
			end else begin
				if (wr_low[i]) begin
					low_r[i] <= writedata[7:0];
				end else if (tick[i]) begin
					low_r[i] <= nxt[i].low;
				end
				if (wr_high[i]) begin
					high_r[i] <= writedata[7:0];
				end else if (i == 0 && mode_split[0]) begin
					if (high_tick) begin
						high_r[i] <= high_r[i] + 8'h01;
					end
				end else if (tick[i]) begin
					high_r[i] <= nxt[i].high;
				end
			end
		end
	end
	assign high_ovf = high_tick & (&high_r[0]);

	// ***************************************************
	// flags, run bits, mode register
	// ***************************************************
	logic [1:0] flag_set; // hardware set per flag
	logic [1:0] flag_clr; // software or vector clear
	assign flag_set[0] = ovf_ev[0];
	assign flag_set[1] = mode_split[0] ? high_ovf : ovf_ev[1];
	assign flag_clr[0] = vector_ack_first |
		(wr_timer_control & ~writedata[dtc_pkg::POS_OVERFLOW_FLAG_FIRST]);
	assign flag_clr[1] = vector_ack_second |
		(wr_timer_control & ~writedata[dtc_pkg::POS_OVERFLOW_FLAG_SECOND]);

	// set wins over any clear arriving in the same cycle
	always_ff @(posedge clk) begin
		if (rst) begin
			flag_r <= {dtc_pkg::TIMER_CONTROL_RST[dtc_pkg::POS_OVERFLOW_FLAG_SECOND],
				dtc_pkg::TIMER_CONTROL_RST[dtc_pkg::POS_OVERFLOW_FLAG_FIRST]};
			run_r <= {dtc_pkg::TIMER_CONTROL_RST[dtc_pkg::POS_RUN_BIT_SECOND],
				dtc_pkg::TIMER_CONTROL_RST[dtc_pkg::POS_RUN_BIT_FIRST]};
			timer_mode_control_r <= dtc_pkg::TIMER_MODE_CONTROL_RST;
		end else begin
			for (int f = 0; f < 2; f++) begin
				if (flag_set[f]) begin
					flag_r[f] <= 1'b1;
				end else if (flag_clr[f]) begin
					flag_r[f] <= 1'b0;
				end else if (wr_timer_control) begin
					flag_r[f] <= writedata[f == 0 ? dtc_pkg::POS_OVERFLOW_FLAG_FIRST :
						dtc_pkg::POS_OVERFLOW_FLAG_SECOND];
				end
			end
			if (wr_timer_control) begin
				run_r <= {writedata[dtc_pkg::POS_RUN_BIT_SECOND],
					writedata[dtc_pkg::POS_RUN_BIT_FIRST]};
			end
			if (wr_timer_mode_control) begin
				timer_mode_control_r <= writedata[7:0];
			end
		end
	end

	// ***************************************************
	// interrupt status, mask, outputs
	// ***************************************************
	logic irq_r; // interrupt line flop
	logic baud_r; // second timer overflow pulse
	always_ff @(posedge clk) begin
		if (rst) begin
			stat_r <= dtc_pkg::IRQ_RST;
			mask_r <= dtc_pkg::IRQ_RST;
			irq_r <= 1'b0;
			baud_r <= 1'b0;
		end else begin
			// new event beats write-one-to-clear
			stat_r <= flag_set | (stat_r & ~(wr_stat ? writedata[1:0] : 2'h0));
			if (wr_mask) begin
				mask_r <= writedata[1:0];
			end
			irq_r <= |(stat_r & mask_r);
			baud_r <= ovf_ev[1];
		end
	end
	assign irq = irq_r;
	assign baud_tick = baud_r;
	assign overflow_flag_first = flag_r[0];
	assign overflow_flag_second = flag_r[1];

	// ***************************************************
	// assertions
	// ***************************************************
	logic [1:0] mode_first; // helper for properties
	assign mode_first = {timer_mode_control_r.first.mode_select_high, timer_mode_control_r.first.mode_select_low};

	property p_phase_period;
		@(posedge clk) disable iff (rst) update_stb |-> ##12 update_stb;
	endproperty
	a_phase_period: assert property (p_phase_period) else $error("machine cycle not twelve clocks");

	property p_timer_inc;
		@(posedge clk) disable iff (rst)
		(tick[0] && mode_first == 2'b01 && !wr_low[0] && !wr_high[0])
		|=> {high_r[0], low_r[0]} == $past({high_r[0], low_r[0]}) + 16'h0001;
	endproperty
	a_timer_inc: assert property (p_timer_inc) else $error("16-bit count did not step");

	property p_stopped_holds;
		@(posedge clk) disable iff (rst) (!run_r[0] && !wr_low[0]) |=> $stable(low_r[0]);
	endproperty
	a_stopped_holds: assert property (p_stopped_holds) else $error("stopped timer counted");

	property p_gate_closed;
		@(posedge clk) disable iff (rst) (timer_mode_control_r.first.gate && !pin_sync_r[2]) |-> !tick[0];
	endproperty
	a_gate_closed: assert property (p_gate_closed) else $error("closed gate let a count through");

	property p_edge_count;
		@(posedge clk) disable iff (rst)
		(sample_stb && sel_ct[0] && smp_r[0] && !pin_sync_r[0] && gate_open[0] && !wr_timer_control && !wr_timer_mode_control)
		|-> ##7 tick[0];
	endproperty
	a_edge_count: assert property (p_edge_count) else $error("falling edge not counted at update");

	property p_ovf_flag;
		@(posedge clk) disable iff (rst) flag_set[0] |=> flag_r[0] && stat_r[0];
	endproperty
	a_ovf_flag: assert property (p_ovf_flag) else $error("overflow did not set flag");

	property p_reload;
		@(posedge clk) disable iff (rst)
		(tick[0] && mode_first == 2'b10 && low_r[0] == 8'hFF && !wr_low[0] && !wr_high[0])
		|=> low_r[0] == high_r[0] && $stable(high_r[0]);
	endproperty
	a_reload: assert property (p_reload) else $error("auto-reload wrong");

	property p_second_split_holds;
		@(posedge clk) disable iff (rst) (mode_split[1] && !wr_low[1] && !wr_high[1])
		|=> $stable(low_r[1]) && $stable(high_r[1]);
	endproperty
	a_second_split_holds: assert property (p_second_split_holds) else $error("second timer ran in mode 3");

	property p_no_own_irq;
		@(posedge clk) disable iff (rst) (mode_split[0] && ovf_ev[1] && !high_ovf && !flag_r[1] && !wr_timer_control)
		|=> !flag_r[1];
	endproperty
	a_no_own_irq: assert property (p_no_own_irq) else $error("second timer flagged while borrowed");

	property p_irq_level;
		@(posedge clk) disable iff (rst) (|(stat_r & mask_r)) |=> irq;
	endproperty
	a_irq_level: assert property (p_irq_level) else $error("interrupt not raised");

	// vector clear must win whenever no new overflow lands in the same cycle
	property p_vector_clear;
		@(posedge clk) disable iff (rst) (vector_ack_first && !flag_set[0]) |=> !flag_r[0];
	endproperty
	a_vector_clear: assert property (p_vector_clear) else $error("vector did not clear flag");

	// prescaler carry must not leak into the three unused low bits
	property p_mode0_upper;
		@(posedge clk) disable iff (rst) (tick[0] && mode_first == 2'b00 && !wr_low[0]) |=> $stable(low_r[0][7:5]);
	endproperty
	a_mode0_upper: assert property (p_mode0_upper) else $error("mode 0 touched upper low bits");

	// serial channel still needs its tick while the flag is borrowed
	property p_baud_pulse;
		@(posedge clk) disable iff (rst) ovf_ev[1] |=> baud_tick;
	endproperty
	a_baud_pulse: assert property (p_baud_pulse) else $error("no baud pulse on overflow");

	c_mode0_wrap: cover property (@(posedge clk) disable iff (rst) ovf_ev[0] && mode_first == 2'b00);
	c_reload: cover property (@(posedge clk) disable iff (rst) ovf_ev[0] && mode_first == 2'b10);
	c_split_high: cover property (@(posedge clk) disable iff (rst) high_ovf);
	c_irq: cover property (@(posedge clk) disable iff (rst) irq);

endmodule : dtc_timer

// *** hw/dtc_pkg.sv ***
// Operation
// - timer mode counts every machine cycle of twelve
// - counter mode samples pin, counts high-then-low
// - edge count appears at fixed later phase
// - run bit switches each timer on/off
// - overflow flag set; cleared on vector
// - count only if run and gate open
// - select bit picks pin edges or cycles
// - mode 0: 13 bits, 5-bit prescaler
// - wrap to zero sets overflow flag
// - setting run bit keeps count contents
// - gate bits at mode bit 7 and 3
// - mode 1: full 16-bit counter
// - mode 2: low byte auto-reloads from high
// - second timer in mode 3 holds count
// - first mode 3: high byte borrows second's controls
// - second timer runs on, raises no interrupt
package dtc_pkg;

	// ***************************************************
	// register indices, byte address is four times these
	// ***************************************************
	localparam logic [7:0] IDX_TIMER_CONTROL = 8'h88; // run and overflow bits
	localparam logic [7:0] IDX_TIMER_MODE_CONTROL = 8'h89; // gate, select, mode per timer
	localparam logic [7:0] IDX_LOW_COUNT_BYTE_FIRST = 8'h8A; // first timer low byte
	localparam logic [7:0] IDX_LOW_COUNT_BYTE_SECOND = 8'h8B; // second timer low byte
	localparam logic [7:0] IDX_HIGH_COUNT_BYTE_FIRST = 8'h8C; // first timer high byte
	localparam logic [7:0] IDX_HIGH_COUNT_BYTE_SECOND = 8'h8D; // second timer high byte
	localparam logic [7:0] IDX_IRQ_STATUS = 8'h8E; // sticky events, write one clears
	localparam logic [7:0] IDX_IRQ_MASK = 8'h8F; // same layout as status
	localparam int ADDR_W = 10; // byte address width

	// ***************************************************
	// field positions and reset values
	// ***************************************************
	localparam int POS_OVERFLOW_FLAG_SECOND = 7;
	localparam int POS_RUN_BIT_SECOND = 6;
	localparam int POS_OVERFLOW_FLAG_FIRST = 5;
	localparam int POS_RUN_BIT_FIRST = 4;
	localparam logic [7:0] TIMER_CONTROL_RST = 8'h00;
	localparam logic [7:0] TIMER_MODE_CONTROL_RST = 8'h00;
	localparam logic [7:0] COUNT_BYTE_RST = 8'h00;
	localparam logic [1:0] IRQ_RST = 2'h0;

	// ***************************************************
	// machine cycle timing, clk is the oscillator
	// ***************************************************
	localparam int OSC_PER_MACHINE_CYCLE = 12; // oscillator periods per cycle
	localparam logic [3:0] PHASE_LAST = 4'(OSC_PER_MACHINE_CYCLE - 1);
	localparam logic [3:0] INPUT_SAMPLE_PHASE = 4'h9; // state 5 phase 2
	localparam logic [3:0] COUNT_UPDATE_PHASE = 4'h4; // state 3 phase 1

	// mode select codes
	typedef enum logic [1:0] {
		MODE_13BIT = 2'b00,
		MODE_16BIT = 2'b01,
		MODE_RELOAD = 2'b10,
		MODE_SPLIT = 2'b11
	} dtc_mode_t;

	// one nibble of the mode register
	typedef struct packed {
		logic gate;
		logic count_select;
		logic mode_select_high;
		logic mode_select_low;
	} dtc_mode_nib_t;

	// whole mode register, second timer on top
	typedef struct packed {
		dtc_mode_nib_t second;
		dtc_mode_nib_t first;
	} dtc_mode_reg_t;

	// result of one counting step
	typedef struct packed {
		logic [7:0] low;
		logic [7:0] high;
		logic ovf;
	} dtc_step_t;

endpackage : dtc_pkg

// *** tb/dtc_pins_model.sv ***
`timescale 1ns/100ps
// ************
// external count and gate pins
// ************
module dtc_pins_model (
	input wire logic clk,
	output logic count_first,
	output logic count_second,
	output logic gate_first,
	output logic gate_second
);
	// pins idle high, gates open
	initial begin
		count_first = 1'b1;
		count_second = 1'b1;
		gate_first = 1'b1;
		gate_second = 1'b1;
	end

	// one level on one count pin, just after an edge
	task automatic drive(input logic sel, input logic v);
		@(posedge clk);
		if (sel) begin
			count_second <= v;
		end else begin
			count_first <= v;
		end
	endtask : drive

	// n falling edges; each level lasts hold+1 clk, so hold below 11 can be lost by the sampler
	task automatic pulses(input logic sel, input int n, input int hold);
		repeat (n) begin
			drive(sel, 1'b0);
			repeat (hold) @(posedge clk);
			drive(sel, 1'b1);
			repeat (hold) @(posedge clk);
		end
	endtask : pulses

	// gate levels, high lets counting through
	task automatic set_gate(input logic g1, input logic g2);
		@(posedge clk);
		gate_first <= g1;
		gate_second <= g2;
	endtask : set_gate
endmodule : dtc_pins_model

// *** tb/tb_top.sv ***
`timescale 1ns/100ps
module tb_top;
	// ************
	// signals
	// ************
	localparam logic [7:0] TC = dtc_pkg::IDX_TIMER_CONTROL; // short aliases
	localparam logic [7:0] TM = dtc_pkg::IDX_TIMER_MODE_CONTROL;
	localparam logic [7:0] L1 = dtc_pkg::IDX_LOW_COUNT_BYTE_FIRST;
	localparam logic [7:0] L2 = dtc_pkg::IDX_LOW_COUNT_BYTE_SECOND;
	localparam logic [7:0] H1 = dtc_pkg::IDX_HIGH_COUNT_BYTE_FIRST;
	localparam logic [7:0] H2 = dtc_pkg::IDX_HIGH_COUNT_BYTE_SECOND;
	localparam logic [7:0] ST = dtc_pkg::IDX_IRQ_STATUS;
	localparam logic [7:0] MK = dtc_pkg::IDX_IRQ_MASK;
	logic clk = 1'b0; // oscillator
	logic rst = 1'b1;
	logic [dtc_pkg::ADDR_W-1:0] address = '0;
	logic read = 1'b0;
	logic write = 1'b0;
	logic [31:0] writedata = 32'h0000_0000;
	logic [31:0] readdata;
	logic waitrequest;
	logic cnt1, cnt2, gt1, gt2; // pins from the model
	logic ack1 = 1'b0; // vector pulses
	logic ack2 = 1'b0;
	logic flag1, flag2, baud_tick, irq;
	logic [31:0] rd; // last read word
	int error_cnt = 0;
	int total_checks = 0;
	int baud_cnt = 0; // baud pulses seen
	int baud_base = 0; // baud count at the start of a scenario
	logic [7:0] regs [8] = '{TC, TM, L1, L2, H1, H2, ST, MK};

	always #5 clk = ~clk;

	// count baud pulses of the second timer
	always @(posedge clk) begin
		if (baud_tick === 1'b1) begin
			baud_cnt <= baud_cnt + 1;
		end
	end

	dtc_pins_model pins (
		.clk(clk),
		.count_first(cnt1),
		.count_second(cnt2),
		.gate_first(gt1),
		.gate_second(gt2)
	);

	dtc_timer DUT (
		.clk(clk),
		.rst(rst),
		.address(address),
		.read(read),
		.write(write),
		.writedata(writedata),
		.readdata(readdata),
		.waitrequest(waitrequest),
		.count_input_first(cnt1),
		.count_input_second(cnt2),
		.gate_input_first(gt1),
		.gate_input_second(gt2),
		.vector_ack_first(ack1),
		.vector_ack_second(ack2),
		.overflow_flag_first(flag1),
		.overflow_flag_second(flag2),
		.baud_tick(baud_tick),
		.irq(irq)
	);

	// ************
	// tasks
	// ************
	task end_of_test;
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : end_of_test

	// byte compare
	task chk8(input string nm, input logic [7:0] exp, input logic [7:0] got);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk8

	// bit compare
	task chk1(input string nm, input logic exp, input logic got);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected %s expected %b seen %b", nm, exp, got);
		end
	endtask : chk1

	// one avalon transfer; request held until the edge that sees waitrequest low
	task bus(input logic we, input logic [7:0] idx, input logic [7:0] wd);
		@(posedge clk);
		address <= {idx, 2'b00};
		write <= we;
		read <= ~we;
		writedata <= {24'h00_0000, wd};
		@(posedge clk);
		// only the watchdog ends a wait that never finishes
		while (waitrequest !== 1'b0) begin
			@(posedge clk);
		end
		rd = readdata;
		read <= 1'b0;
		write <= 1'b0;
	endtask : bus

	task rdchk(input logic [7:0] idx, input logic [7:0] exp, input string nm);
		bus(1'b0, idx, 8'h00);
		chk8(nm, exp, rd[7:0]);
	endtask : rdchk

	// run for exactly k machine cycles: write edges 12k apart
	task run_for(input logic [7:0] ctl, input int k);
		bus(1'b1, TC, ctl);
		repeat (12 * k - 3) @(posedge clk);
		bus(1'b1, TC, 8'h00);
	endtask : run_for

	// ************
	// tests
	// ************
	initial begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		foreach (regs[i]) rdchk(regs[i], 8'h00, "reset value");
		rdchk(8'h00, 8'h00, "unmapped");
		// sixteen bit timer, carry into high byte, contents kept
		bus(1'b1, TM, 8'h01);
		bus(1'b1, L1, 8'hFD);
		bus(1'b1, H1, 8'h20);
		run_for(8'h10, 5);
		rdchk(L1, 8'h02, "low1 mode1");
		rdchk(H1, 8'h21, "high1 mode1");
		// wrap, flag, interrupt, vector clear
		bus(1'b1, L1, 8'hFF);
		bus(1'b1, H1, 8'hFF);
		bus(1'b1, MK, 8'h01);
		bus(1'b1, TC, 8'h10);
		repeat (24) @(negedge clk);
		chk1("flag1", 1'b1, flag1);
		chk1("irq", 1'b1, irq);
		@(posedge clk);
		ack1 <= 1'b1;
		@(posedge clk);
		ack1 <= 1'b0;
		@(negedge clk);
		chk1("flag1 vector", 1'b0, flag1);
		bus(1'b1, TC, 8'h00);
		rdchk(ST, 8'h01, "status");
		bus(1'b1, MK, 8'h00);
		repeat (2) @(negedge clk);
		chk1("irq masked", 1'b0, irq);
		bus(1'b1, ST, 8'h03);
		bus(1'b1, MK, 8'h03);
		rdchk(ST, 8'h00, "status cleared");
		chk1("irq cleared", 1'b0, irq);
		// thirteen bit mode, carry at 32
		bus(1'b1, TM, 8'h00);
		bus(1'b1, L1, 8'hFE);
		bus(1'b1, H1, 8'h05);
		run_for(8'h10, 3);
		rdchk(L1, 8'hE1, "low1 mode0");
		rdchk(H1, 8'h06, "high1 mode0");
		// auto reload
		bus(1'b1, TM, 8'h02);
		bus(1'b1, H1, 8'h80);
		bus(1'b1, L1, 8'hFE);
		run_for(8'h10, 3);
		rdchk(L1, 8'h81, "low1 reload");
		rdchk(H1, 8'h80, "high1 reload");
		rdchk(ST, 8'h01, "status reload");
		bus(1'b1, ST, 8'h03);
		// pin edges on both timers, fast and slow sources
		bus(1'b1, TM, 8'h55);
		bus(1'b1, L1, 8'h00);
		bus(1'b1, L2, 8'h00);
		bus(1'b1, TC, 8'h50);
		pins.pulses(1'b0, 3, 14);
		pins.pulses(1'b1, 2, 30);
		repeat (30) @(posedge clk);
		bus(1'b1, TC, 8'h00);
		rdchk(L1, 8'h03, "edges1");
		rdchk(L2, 8'h02, "edges2");
		// gating, one gate opened
		bus(1'b1, TM, 8'h99);
		bus(1'b1, L1, 8'h00);
		bus(1'b1, L2, 8'h00);
		pins.set_gate(1'b0, 1'b0);
		repeat (5) @(posedge clk);
		run_for(8'h50, 4);
		rdchk(L1, 8'h00, "gated low1");
		pins.set_gate(1'b1, 1'b0);
		repeat (5) @(posedge clk);
		run_for(8'h50, 4);
		rdchk(L1, 8'h04, "open low1");
		rdchk(L2, 8'h00, "gated low2");
		pins.set_gate(1'b1, 1'b1);
		// split mode: high byte borrows second run bit and flag
		bus(1'b1, TM, 8'h37);
		bus(1'b1, L1, 8'h00);
		bus(1'b1, H1, 8'hFE);
		bus(1'b1, L2, 8'h10);
		run_for(8'h50, 3);
		rdchk(L1, 8'h00, "split low1");
		rdchk(H1, 8'h01, "split high1");
		rdchk(L2, 8'h10, "held low2");
		rdchk(ST, 8'h02, "split status");
		bus(1'b1, ST, 8'h03);
		// second timer runs on silently
		bus(1'b1, TM, 8'h17);
		bus(1'b1, L2, 8'hFF);
		bus(1'b1, H2, 8'hFF);
		baud_base = baud_cnt;
		run_for(8'h40, 1);
		rdchk(L2, 8'h00, "low2 wrap");
		rdchk(H2, 8'h00, "high2 wrap");
		rdchk(ST, 8'h00, "no second irq");
		chk8("baud", 8'h01, 8'(baud_cnt - baud_base));
		// second flag cleared by its vector
		bus(1'b1, TC, 8'h80);
		@(negedge clk);
		chk1("flag2 written", 1'b1, flag2);
		@(posedge clk);
		ack2 <= 1'b1;
		@(posedge clk);
		ack2 <= 1'b0;
		@(negedge clk);
		chk1("flag2 vector", 1'b0, flag2);
		end_of_test;
	end

	// hang guard, well past the fewer than a thousand cycles used
	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		end_of_test;
	end
endmodule : tb_top
